/* rhb_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the clock host port.
 * Assumes inclusion by the port module and the bench only.
 */
`ifndef RHB_CONSTS_SVH
`define RHB_CONSTS_SVH

// ************************************************************
// Clock location map
// ************************************************************
`define RHB_CLK_LOCS 64
`define RHB_LOC_A 6'h0a
`define RHB_LOC_B 6'h0b
`define RHB_LOC_C 6'h0c
`define RHB_LOC_D 6'h0d

// ************************************************************
// Field positions
// ************************************************************
`define RHB_A_RO_BIT 7
`define RHB_B_PIE_BIT 6
`define RHB_B_AIE_BIT 5
`define RHB_B_UIE_BIT 4
`define RHB_B_SQUARE_WAVE_ENABLE_BIT 3
`define RHB_C_SUMMARY_IRQ_FLAG_BIT 7
`define RHB_C_PF_BIT 6
`define RHB_C_AF_BIT 5
`define RHB_C_UF_BIT 4
`define RHB_B_CLR_MASK 7'h07

// ************************************************************
// Extended RAM layout and timing
// ************************************************************
`define RHB_PAGE_BYTES 32
`define RHB_PAGES 128
`define RHB_PAGE_SEL_BIT 5
`define RHB_PRESCALE 16'h0002
`define RHB_RESET_BYTE 8'h00

`endif

/* rhb_pkg.sv */
/*
 * Types shared by the clock host port.
 * Assumes the constants header sits in the same folder.
 */
package rhb_pkg;

   typedef logic [7:0] rhb_byte_t;
   typedef logic [5:0] rhb_addr_t;

   // Destination of a bus access after address decode.
   typedef enum logic [2:0]
   {
      rhb_tgt_none,
      rhb_tgt_index,
      rhb_tgt_window,
      rhb_tgt_page,
      rhb_tgt_ram
   } rhb_target_e;

endpackage : rhb_pkg

/* rhb_host_port.sv */
/*
 * Processor-side parallel port of a real time clock with a paged extended RAM.
 * Assumes all bus pins, the standby pin and the reset pin are asynchronous to clk_i,
 * and that the timekeeping core supplies alarm and update-ended pulses on clk_i.
 */
// Contract
// - Write the addressed location on the write strobe rising edge when selected.
// - Drive selected contents on the data bus while read strobe low and selected.
// - Under clock select only A0 chooses pointer or data register.
// - A0 low reaches the pointer; A0 high the window into 64 locations.
// - Under RAM select with A5 high the access goes to the page register.
// - Under RAM select with A5 low A0-A4 pick a byte in the page.
// - Page register picks one of 128 pages and aliases across low addresses.
// - Standby low ignores all accesses and floats every output; the code drives the square wave output low instead of floating it.
// - Standby keeps RAM contents and timekeeping running.
// - Standby during a cycle ends it at the earlier of cycle end or standby.
// - Square wave frequency comes from four rate select bits in register A.
// - Interrupt request is an active-low open-drain output.
// - Interrupt pin follows the summary flag, bit 7 of register C.
// - Alarm, update-ended and periodic events raise the request per register B enables.
// - Reset low clears the three enables, three flags, summary flag and square enable.
// - Reset low floats the interrupt request output.
// - Reset low refuses processor access to the clock section.
`include "rhb_consts.svh"
module rhb_host_port
   import rhb_pkg::*;
#(
   parameter int RAM_PAGES = `RHB_PAGES,
   parameter logic [15:0] PRESCALE = `RHB_PRESCALE
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bus pins
   input wire logic clock_select_n_i,
   input wire logic ext_ram_select_n_i,
   input wire rhb_pkg::rhb_addr_t address_lines_i,
   input wire rhb_pkg::rhb_byte_t data_lines_i,
   output rhb_pkg::rhb_byte_t data_lines_o,
   output logic data_lines_oe_o,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   // Control pins
   input wire logic standby_n_i,
   input wire logic reset_n_i,
   // Timekeeping events
   input wire logic alarm_event_i,
   input wire logic update_event_i,
   // Outputs
   output logic irq_n_o,
   output logic irq_n_oe_o,
   output logic square_wave_out_o
);
   import rhb_pkg::*;

   localparam int PAGE_W = $clog2(RAM_PAGES);
   localparam int SYNC_W = 20;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [SYNC_W-1:0] pins_raw, sync_a, sync_b;

   assign pins_raw = {clock_select_n_i, ext_ram_select_n_i, address_lines_i, data_lines_i,
                      rd_n_i, wr_n_i, standby_n_i, reset_n_i};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               sync_a[gi] <= 1'b1;
               sync_b[gi] <= 1'b1;
            end
            else
            begin
               sync_a[gi] <= pins_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic clk_sel_n, ram_sel_n, rd_n, wr_n, standby_n_n, pin_rst_n;
   rhb_addr_t addr;
   rhb_byte_t din;

   assign {clk_sel_n, ram_sel_n, addr, din, rd_n, wr_n, standby_n_n, pin_rst_n} = sync_b;

   // ************************************************************
   // Address decode
   // ************************************************************
   rhb_target_e target;
   logic access_ok;

   // Standby blocks everything; reset only blocks the clock section.
   assign access_ok = standby_n_n;

   always_comb
   begin
      target = rhb_tgt_none;
      if (access_ok && !clk_sel_n && pin_rst_n)
         target = addr[0] ? rhb_tgt_window : rhb_tgt_index;
      else if (access_ok && !ram_sel_n)
         target = addr[`RHB_PAGE_SEL_BIT] ? rhb_tgt_page : rhb_tgt_ram;
   end

   // ************************************************************
   // Storage
   // ************************************************************
   logic [5:0] index;
   logic [PAGE_W-1:0] page;
   rhb_byte_t clk_loc [`RHB_CLK_LOCS];
   rhb_byte_t ram [RAM_PAGES*`RHB_PAGE_BYTES];
   logic [PAGE_W+4:0] ram_idx, wr_ram_idx;

   assign ram_idx = {page, addr[4:0]};

   // ************************************************************
   // Write capture
   // ************************************************************
   // The strobe low phase refreshes the captured address and data each cycle,
   // so the values present just before the rising edge are the ones stored.
   logic wr_armed, next_wr_armed, commit;
   rhb_target_e wr_tgt, next_wr_tgt;
   rhb_addr_t wr_addr, next_wr_addr;
   rhb_byte_t wr_data, next_wr_data;

   always_comb
   begin
      next_wr_armed = wr_armed;
      next_wr_tgt = wr_tgt;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      if (!wr_n && target != rhb_tgt_none)
      begin
         next_wr_armed = 1'b1;
         next_wr_tgt = target;
         next_wr_addr = addr;
         next_wr_data = din;
      end
      else
         next_wr_armed = 1'b0;
   end

   // A cycle dropped by standby or by select loss never commits.
   assign commit = wr_armed && wr_n && access_ok;
   assign wr_ram_idx = {page, wr_addr[4:0]};

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_armed <= 1'b0;
         wr_tgt <= rhb_tgt_none;
         wr_addr <= '0;
         wr_data <= '0;
      end
      else
      begin
         wr_armed <= next_wr_armed;
         wr_tgt <= next_wr_tgt;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   // RAM and general clock bytes carry no reset; contents survive standby and pin reset.
   always_ff @(posedge clk_i)
   begin
      if (commit && wr_tgt == rhb_tgt_ram)
         ram[wr_ram_idx] <= wr_data;
      if (commit && wr_tgt == rhb_tgt_window && index != `RHB_LOC_B
          && index != `RHB_LOC_C && index != `RHB_LOC_D)
         clk_loc[index] <= wr_data;
   end

   // ************************************************************
   // Pointer, page and control registers
   // ************************************************************
   logic [6:0] ctrl_b, next_ctrl_b;
   logic [5:0] next_index;
   logic [PAGE_W-1:0] next_page;
   logic pf, af, uf, next_pf, next_af, next_uf;
   logic periodic_evt, rd_c, rd_c_q, summary_irq_flag;

   assign rd_c = target == rhb_tgt_window && !rd_n && index == `RHB_LOC_C;

   always_comb
   begin
      next_index = index;
      next_page = page;
      next_ctrl_b = ctrl_b;
      next_pf = pf;
      next_af = af;
      next_uf = uf;
      if (commit && wr_tgt == rhb_tgt_index)
         next_index = wr_addr[0] ? index : wr_data[5:0];
      if (commit && wr_tgt == rhb_tgt_page)
         next_page = wr_data[PAGE_W-1:0];
      if (commit && wr_tgt == rhb_tgt_window && index == `RHB_LOC_B)
         next_ctrl_b = wr_data[6:0];
      // Flags clear when a read of the status byte ends; a new event wins.
      if (rd_c_q && !rd_c)
      begin
         next_pf = 1'b0;
         next_af = 1'b0;
         next_uf = 1'b0;
      end
      if (periodic_evt)
         next_pf = 1'b1;
      if (alarm_event_i)
         next_af = 1'b1;
      if (update_event_i)
         next_uf = 1'b1;
      if (!pin_rst_n)
      begin
         next_ctrl_b = next_ctrl_b & `RHB_B_CLR_MASK;
         next_pf = 1'b0;
         next_af = 1'b0;
         next_uf = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         index <= '0;
         page <= '0;
         ctrl_b <= '0;
         pf <= 1'b0;
         af <= 1'b0;
         uf <= 1'b0;
         rd_c_q <= 1'b0;
      end
      else
      begin
         index <= next_index;
         page <= next_page;
         ctrl_b <= next_ctrl_b;
         pf <= next_pf;
         af <= next_af;
         uf <= next_uf;
         rd_c_q <= rd_c;
      end
   end

   // Summary flag is combined from enabled flags, so it clears together with them.
   assign summary_irq_flag = (pf && ctrl_b[`RHB_B_PIE_BIT]) || (af && ctrl_b[`RHB_B_AIE_BIT])
                 || (uf && ctrl_b[`RHB_B_UIE_BIT]);

   // ************************************************************
   // Rate divider and square wave
   // ************************************************************
   // Runs regardless of standby so periodic timing never stalls.
   logic [15:0] pre_cnt, next_pre_cnt;
   logic [14:0] div_cnt, next_div_cnt;
   logic [3:0] rate_select_bits;
   logic tap, tap_q, square_wave_out, next_sqw;

   assign rate_select_bits = clk_loc[`RHB_LOC_A][3:0];
   assign tap = rate_select_bits != 4'h0 && div_cnt[rate_select_bits - 4'h1];
   assign periodic_evt = tap && !tap_q;

   always_comb
   begin
      next_pre_cnt = pre_cnt + 16'h0001;
      next_div_cnt = div_cnt;
      if (pre_cnt >= PRESCALE - 16'h0001)
      begin
         next_pre_cnt = 16'h0000;
         next_div_cnt = div_cnt + 15'h0001;
      end
      next_sqw = tap && ctrl_b[`RHB_B_SQUARE_WAVE_ENABLE_BIT] && pin_rst_n;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_cnt <= '0;
         div_cnt <= '0;
         tap_q <= 1'b0;
         square_wave_out <= 1'b0;
      end
      else
      begin
         pre_cnt <= next_pre_cnt;
         div_cnt <= next_div_cnt;
         tap_q <= tap;
         square_wave_out <= next_sqw;
      end
   end

   // ************************************************************
   // Read path and pin drivers
   // ************************************************************
   rhb_byte_t next_rd_data, rd_data, window_val;

   always_comb
   begin
      case (index)
         `RHB_LOC_B: window_val = {1'b0, ctrl_b};
         `RHB_LOC_C: window_val = {summary_irq_flag, pf, af, uf, 4'h0};
         `RHB_LOC_D: window_val = `RHB_RESET_BYTE;
         default: window_val = clk_loc[index];
      endcase
      case (target)
         rhb_tgt_index: next_rd_data = {2'b00, index};
         rhb_tgt_window: next_rd_data = window_val;
         rhb_tgt_page: next_rd_data = {{(8 - PAGE_W){1'b0}}, page};
         rhb_tgt_ram: next_rd_data = ram[ram_idx];
         default: next_rd_data = `RHB_RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rd_data <= '0;
      else
         rd_data <= next_rd_data;
   end

   assign data_lines_o = rd_data;
   assign data_lines_oe_o = !rd_n && target != rhb_tgt_none;
   assign irq_n_o = 1'b0;
   assign irq_n_oe_o = summary_irq_flag && pin_rst_n && standby_n_n;
   assign square_wave_out_o = square_wave_out && standby_n_n;

endmodule : rhb_host_port

/* rhb_host_port_asserts.sv */
/*
 * Concurrent checks on the clock host port, watching its ports only.
 * Assumes every bus pin passes two synchroniser flops before it acts.
 */
module rhb_host_port_asserts
   import rhb_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins
   input wire logic clock_select_n_i,
   input wire logic ext_ram_select_n_i,
   input wire logic rd_n_i,
   input wire logic standby_n_i,
   input wire logic reset_n_i,
   // Outputs
   input wire logic data_lines_oe_o,
   input wire logic irq_n_o,
   input wire logic irq_n_oe_o,
   input wire logic square_wave_out_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_irq_open_drain: assert property (irq_n_o == 1'b0)
      else $error("irq pin data not low");
   a_reset_irq_float: assert property (!reset_n_i [*4] |-> !irq_n_oe_o)
      else $error("irq pulled low during device reset");
   a_standby_bus_float: assert property (!standby_n_i [*3] |-> !data_lines_oe_o)
      else $error("bus driven in standby");
   a_unselected_float: assert property
      ((clock_select_n_i && ext_ram_select_n_i) [*3] |-> !data_lines_oe_o)
      else $error("bus driven without select");
   a_rd_end_float: assert property ($rose(rd_n_i) |-> ##[1:2] !data_lines_oe_o)
      else $error("bus still driven after read");
   a_ram_read_drives: assert property
      ((!rd_n_i && !ext_ram_select_n_i && clock_select_n_i && standby_n_i) [*3]
      |-> data_lines_oe_o)
      else $error("ram read not driven");
   a_reset_clock_refused: assert property
      ((!reset_n_i && !clock_select_n_i && !rd_n_i) [*4] |-> !data_lines_oe_o)
      else $error("clock section read during device reset");
   a_reset_square_off: assert property (!reset_n_i [*5] |-> !square_wave_out_o)
      else $error("square wave runs during device reset");

endmodule : rhb_host_port_asserts

bind rhb_host_port rhb_host_port_asserts rhb_host_port_asserts_i (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .clock_select_n_i(clock_select_n_i),
   .ext_ram_select_n_i(ext_ram_select_n_i), .rd_n_i(rd_n_i), .standby_n_i(standby_n_i),
   .reset_n_i(reset_n_i), .data_lines_oe_o(data_lines_oe_o), .irq_n_o(irq_n_o),
   .irq_n_oe_o(irq_n_oe_o), .square_wave_out_o(square_wave_out_o));

/* rhb_host_model.sv */
/*
 * Host processor model that drives the bus pins of the clock host port.
 * Assumes one shared clock and tasks called one after another.
 */
module rhb_host_model
   import rhb_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Device side of the data wire
   input wire rhb_pkg::rhb_byte_t dev_data_i,
   input wire logic dev_oe_i,
   // Bus pins
   output logic clock_select_n_o,
   output logic ext_ram_select_n_o,
   output rhb_pkg::rhb_addr_t addr_o,
   output rhb_pkg::rhb_byte_t bus_o,
   output logic rd_n_o,
   output logic wr_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import rhb_pkg::*;
   rhb_byte_t wdata = 8'h00;
   logic drive = 1'b0;

   // A released wire shows the inverse of the last value, so a stale copy never passes.
   assign bus_o = dev_oe_i ? dev_data_i : (drive ? wdata : ~wdata);

   initial
   begin
      clock_select_n_o = 1'b1;
      ext_ram_select_n_o = 1'b1;
      addr_o = 6'h00;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
   end

   // ************************************************************
   // One access; strobes stay long enough to survive the synchronisers
   // ************************************************************
   task automatic cycle(input logic ram, input rhb_addr_t a, input logic w,
                        input rhb_byte_t d, output rhb_byte_t q, output logic oe);
      @(posedge clk_i);
      clock_select_n_o <= ram;
      ext_ram_select_n_o <= !ram;
      addr_o <= a;
      wdata <= d;
      drive <= w;
      wr_n_o <= !w;
      rd_n_o <= w;
      repeat (4) @(posedge clk_i);
      q = bus_o;
      oe = dev_oe_i;
      wr_n_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      clock_select_n_o <= 1'b1;
      ext_ram_select_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      drive <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : cycle

endmodule : rhb_host_model

/* rtc_host_bus_interface_bench.sv */
/*
 * Self-checking bench of the clock host port with a host model on its bus.
 * Assumes the constants header and the package sit in the same folder.
 */
`include "rhb_consts.svh"
module rtc_host_bus_interface_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import rhb_pkg::*;
   typedef struct {logic ram; rhb_addr_t a; logic w; rhb_byte_t d;} rhb_row_s;
   localparam logic [15:0] PRESCALE = 16'h0002;
   localparam int SQ_RISES = 160 / (PRESCALE * 8);
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic standby_n = 1'b1;
   logic reset_n = 1'b1;
   logic alarm_ev = 1'b0;
   logic update_ev = 1'b0;
   logic cs_n, xs_n, rd_n, wr_n, oe, irq_n, irq_oe, sq, qoe;
   rhb_addr_t addr;
   rhb_byte_t din, dout, q;
   int n_fail = 0;
   int num_checks = 0;
   int rises;
   // Reads hold the expected byte in d.
   rhb_row_s rows [11] = '{
      '{1'b0, 6'h2a, 1'b1, 8'hd0}, '{1'b0, 6'h15, 1'b1, 8'h5a}, '{1'b0, 6'h3f, 1'b0, 8'h5a},
      '{1'b1, 6'h20, 1'b1, 8'h01}, '{1'b1, 6'h07, 1'b1, 8'ha5}, '{1'b1, 6'h3f, 1'b1, 8'h02},
      '{1'b1, 6'h07, 1'b1, 8'h3c}, '{1'b1, 6'h07, 1'b0, 8'h3c}, '{1'b1, 6'h21, 1'b1, 8'h01},
      '{1'b1, 6'h07, 1'b0, 8'ha5}, '{1'b1, 6'h2b, 1'b0, 8'h01}};

   always #20 clk_i = ~clk_i;

   rhb_host_port #(.RAM_PAGES(4), .PRESCALE(PRESCALE)) rhb_host_port_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .clock_select_n_i(cs_n), .ext_ram_select_n_i(xs_n),
      .address_lines_i(addr), .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_o(oe),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .standby_n_i(standby_n), .reset_n_i(reset_n),
      .alarm_event_i(alarm_ev), .update_event_i(update_ev), .irq_n_o(irq_n),
      .irq_n_oe_o(irq_oe), .square_wave_out_o(sq));

   rhb_host_model rhb_host_model_i (
      .clk_i(clk_i), .dev_data_i(dout), .dev_oe_i(oe), .clock_select_n_o(cs_n),
      .ext_ram_select_n_o(xs_n), .addr_o(addr), .bus_o(din), .rd_n_o(rd_n), .wr_n_o(wr_n));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      num_checks++;
      if (seen !== want)
      begin
         n_fail++;
         $display("BAD at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask : check

   task automatic reg_acc(input rhb_addr_t loc, input logic w, input rhb_byte_t d);
      rhb_host_model_i.cycle(1'b0, 6'h00, 1'b1, {2'b00, loc}, q, qoe);
      rhb_host_model_i.cycle(1'b0, 6'h01, w, d, q, qoe);
   endtask : reg_acc

   task automatic pulse(input logic al);
      alarm_ev <= al;
      update_ev <= !al;
      @(posedge clk_i);
      alarm_ev <= 1'b0;
      update_ev <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse

   task automatic count_sq();
      logic prev;
      rises = 0;
      prev = sq;
      repeat (160)
      begin
         @(posedge clk_i);
         if (sq === 1'b1 && prev === 1'b0)
            rises++;
         prev = sq;
      end
   endtask : count_sq

   task automatic give_verdict();
      $display("checks %0d, failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   // ************************************************************
   // Tests
   // ************************************************************
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      foreach (rows[i])
      begin
         rhb_host_model_i.cycle(rows[i].ram, rows[i].a, rows[i].w, rows[i].d, q, qoe);
         if (!rows[i].w)
            check(q, rows[i].d, "table read");
      end
      $display("table done");
      standby_n <= 1'b0;
      rhb_host_model_i.cycle(1'b1, 6'h07, 1'b1, 8'hff, q, qoe);
      rhb_host_model_i.cycle(1'b1, 6'h07, 1'b0, 8'h00, q, qoe);
      check({7'h00, qoe}, 8'h00, "standby drive");
      standby_n <= 1'b1;
      rhb_host_model_i.cycle(1'b1, 6'h07, 1'b0, 8'h00, q, qoe);
      check(q, 8'ha5, "standby ram");
      // Standby falls after the write is armed but before its strobe returns.
      fork
         rhb_host_model_i.cycle(1'b1, 6'h07, 1'b1, 8'h77, q, qoe);
         begin
            repeat (3) @(posedge clk_i);
            standby_n <= 1'b0;
         end
      join
      standby_n <= 1'b1;
      rhb_host_model_i.cycle(1'b1, 6'h07, 1'b0, 8'h00, q, qoe);
      check(q, 8'ha5, "write cut by standby");
      $display("standby done");
      reg_acc(`RHB_LOC_B, 1'b1, 8'h20);
      pulse(1'b1);
      check({7'h00, irq_oe}, 8'h01, "alarm irq");
      check({7'h00, irq_n}, 8'h00, "irq pin level");
      reg_acc(`RHB_LOC_C, 1'b0, 8'h00);
      check(q, 8'ha0, "status alarm");
      // Flags clear only after the synchronised read strobe has returned.
      repeat (2) @(posedge clk_i);
      check({7'h00, irq_oe}, 8'h00, "irq after status read");
      pulse(1'b0);
      check({7'h00, irq_oe}, 8'h00, "masked update");
      reg_acc(`RHB_LOC_C, 1'b0, 8'h00);
      check(q, 8'h10, "status update");
      $display("irq done");
      reg_acc(`RHB_LOC_B, 1'b1, 8'h78);
      pulse(1'b1);
      reset_n <= 1'b0;
      rhb_host_model_i.cycle(1'b0, 6'h01, 1'b0, 8'h00, q, qoe);
      check({7'h00, qoe}, 8'h00, "reset clock read");
      check({7'h00, irq_oe}, 8'h00, "reset irq");
      rhb_host_model_i.cycle(1'b0, 6'h00, 1'b1, 8'h10, q, qoe);
      reset_n <= 1'b1;
      rhb_host_model_i.cycle(1'b0, 6'h01, 1'b0, 8'h00, q, qoe);
      check(q, 8'h00, "control after reset");
      reg_acc(`RHB_LOC_C, 1'b0, 8'h00);
      check(q, 8'h00, "status after reset");
      $display("reset done");
      reg_acc(`RHB_LOC_A, 1'b1, 8'h03);
      reg_acc(`RHB_LOC_B, 1'b1, 8'h08);
      count_sq();
      check({7'h00, rises inside {[SQ_RISES - 1:SQ_RISES + 1]}}, 8'h01, "square rate");
      reg_acc(`RHB_LOC_A, 1'b1, 8'h00);
      count_sq();
      check(rises[7:0], 8'h00, "square off");
      $display("square done");
      give_verdict();
   end

   // Whole run needs well under a thousand cycles.
   initial
   begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      $display("BAD at %0t: watchdog", $time);
      give_verdict();
   end

endmodule : rtc_host_bus_interface_bench
